/* rtl/acr_pkg.sv */
// constants for the converter configuration register bank
package acr_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [7:0] IDX_CFG0 = 8'h00;
  localparam logic [7:0] IDX_CFG1 = 8'h01;
  localparam logic [7:0] IDX_CFG2 = 8'h02;
  localparam logic [7:0] IDX_CFG3 = 8'h03;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h08;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h09;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h0A;
  localparam logic [7:0] IDX_RESULT = 8'h0B;
  localparam logic [7:0] IDX_COUNT = 8'h0C;
  localparam logic [7:0] IDX_RATE = 8'h0D;
  localparam int ADDR_W = 8;
  localparam int IDX_LSB = 2;
  // reset value of every configuration register
  localparam logic [7:0] CFG_RESET = 8'h00;
  // register 0 fields
  localparam int C0_MUX_LSB = 4;
  localparam int C0_GAIN_LSB = 1;
  localparam int C0_BYP_BIT = 0;
  // register 1 fields
  localparam int C1_RATE_LSB = 5;
  localparam int C1_TURBO_BIT = 4;
  localparam int C1_CONT_BIT = 3;
  localparam int C1_REF_LSB = 1;
  localparam int C1_TEMP_BIT = 0;
  // register 2 fields
  localparam int C2_READY_BIT = 7;
  localparam int C2_CNT_BIT = 6;
  localparam int C2_CHK_LSB = 4;
  localparam int C2_BURN_BIT = 3;
  localparam int C2_LEVEL_LSB = 0;
  // register 3 fields
  localparam int C3_SRC1_LSB = 5;
  localparam int C3_SRC2_LSB = 2;
  localparam int C3_RSVD_BIT = 1;
  localparam int C3_AUTO_BIT = 0;
  // writable masks
  localparam logic [7:0] C2_WMASK = 8'h7F;
  localparam logic [7:0] C3_WMASK = 8'hFD;
  // interrupt status bits
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_W = 1;
  // rate for the reserved code in samples per second; turbo doubles every code
  localparam logic [11:0] RATE_RESERVED = 12'h000;
  // reference selections
  typedef enum logic [1:0] {
    ACR_REF_INTERNAL,
    ACR_REF_EXTERNAL,
    ACR_REF_SUPPLY
  } acr_ref_t;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : acr_pkg

/* rtl/acr_rate_lut.sv */
// registered lookup of output data rate from rate code and modulator mode
`timescale 1ns/1ps
`default_nettype none
module acr_rate_lut (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // selection
  input wire logic [2:0] rate_code,
  input wire logic turbo,
  // result in samples per second, zero for reserved code
  output logic [11:0] rate_sps
);
  // normal mode rate for a code
  function automatic logic [11:0] acr_normal_rate(input logic [2:0] code);
    unique case (code)
      3'h0: acr_normal_rate = 12'h014;
      3'h1: acr_normal_rate = 12'h02D;
      3'h2: acr_normal_rate = 12'h05A;
      3'h3: acr_normal_rate = 12'h0AF;
      3'h4: acr_normal_rate = 12'h14A;
      3'h5: acr_normal_rate = 12'h258;
      3'h6: acr_normal_rate = 12'h3E8;
      3'h7: acr_normal_rate = acr_pkg::RATE_RESERVED;
    endcase
  endfunction : acr_normal_rate

  // turbo mode rate for a code
  function automatic logic [11:0] acr_turbo_rate(input logic [2:0] code);
    unique case (code)
      3'h0: acr_turbo_rate = 12'h028;
      3'h1: acr_turbo_rate = 12'h05A;
      3'h2: acr_turbo_rate = 12'h0B4;
      3'h3: acr_turbo_rate = 12'h15E;
      3'h4: acr_turbo_rate = 12'h294;
      3'h5: acr_turbo_rate = 12'h4B0;
      3'h6: acr_turbo_rate = 12'h7D0;
      3'h7: acr_turbo_rate = acr_pkg::RATE_RESERVED;
    endcase
  endfunction : acr_turbo_rate

  // registered output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rate_sps <= 12'h000;
    end else if (turbo) begin
      rate_sps <= acr_turbo_rate(rate_code);
    end else begin
      rate_sps <= acr_normal_rate(rate_code);
    end
  end
endmodule : acr_rate_lut
`default_nettype wire

/* rtl/acr_regs.sv */
// configuration registers 0 to 3 of the converter, reached over AXI4-Lite
//
// Notes on behaviour
// - rate code 7:5 picks normal rate
// - turbo mode doubles the rate table
// - bit 4 selects normal or turbo
// - bit 3 selects single or continuous
// - bits 2:1 pick reference source
// - temperature mode overrides register 0, internal ref
// - ready flag set by result, cleared on read
// - bit 6 enables the sample counter
// - bits 5:4 select integrity check
// - bit 3 switches burn-out sources
// - bits 2:0 set excitation level
// - bits 7:5 route first excitation source
// - bits 4:2 route second source
// - reserved bit 1 reads zero
// - bit 0 selects automatic result output
// - registers at 00h to 03h, reset 00h
// - register 0 holds mux, gain, bypass
`timescale 1ns/1ps
`default_nettype none
module acr_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // conversion engine side
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  output logic start_pulse,
  // analog controls
  output logic [3:0] input_mux_sel,
  output logic [2:0] gain_code,
  output logic amp_bypass,
  output logic [2:0] output_rate_code,
  output logic turbo_mode_sel,
  output logic conversion_mode_sel,
  output logic [1:0] reference_sel,
  output logic temp_sensor_mode_en,
  output logic sample_counter_en,
  output logic [1:0] integrity_check_sel,
  output logic burnout_source_en,
  output logic [2:0] excitation_current_level,
  output logic [2:0] exc_src1_route,
  output logic [2:0] exc_src2_route,
  output logic auto_output_en,
  output logic [11:0] output_rate_sps,
  // interrupt
  output logic irq
);
  // stored configuration images
  logic [7:0] cfg0_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic [7:0] cfg3_reg;

  // result, counter and interrupt state
  logic ready_reg;
  logic [15:0] result_reg;
  logic [7:0] count_reg;
  logic [acr_pkg::IRQ_W-1:0] irq_status_reg;
  logic [acr_pkg::IRQ_W-1:0] irq_enable_reg;

  // write halves parked until both are present
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // decoded strobes and read path
  logic do_write;
  logic do_read;
  logic [7:0] w_idx;
  logic [7:0] r_idx;
  logic [7:0] wbyte;
  logic result_read;
  logic clear_ready;
  logic [acr_pkg::IRQ_W-1:0] irq_clear;
  logic [31:0] rdata_next;
  logic rhit;

  // index of a byte address
  function automatic logic [7:0] acr_index(input logic [7:0] addr);
    acr_index = {2'b00, addr[7:acr_pkg::IDX_LSB]};
  endfunction : acr_index

  // true for every index that decodes to a register
  function automatic logic acr_is_mapped(input logic [7:0] idx);
    acr_is_mapped = (idx <= acr_pkg::IDX_CFG3) ||
                    (idx >= acr_pkg::IDX_IRQ_STATUS &&
                     idx <= acr_pkg::IDX_RATE);
  endfunction : acr_is_mapped

  // write channels accepted independently, held until response
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // a write fires once both halves are parked and no response waits
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign w_idx = acr_index(aw_addr_reg);
  assign r_idx = acr_index(s_axi_araddr);
  assign wbyte = w_data_reg[7:0];

  // capture address and data halves
  // a half taken early is parked until its partner arrives
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // write response, error on unmapped index
  // a write to a read-only index answers okay and changes nothing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= acr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= acr_is_mapped(w_idx) ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register data, other lanes are ignored
  // reset 00h
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg0_reg <= acr_pkg::CFG_RESET;
      cfg1_reg <= acr_pkg::CFG_RESET;
      cfg2_reg <= acr_pkg::CFG_RESET;
      cfg3_reg <= acr_pkg::CFG_RESET;
    end else if (do_write && w_strb_reg[0]) begin
      if (w_idx == acr_pkg::IDX_CFG0) begin
        cfg0_reg <= wbyte;
      end
      if (w_idx == acr_pkg::IDX_CFG1) begin
        cfg1_reg <= wbyte;
      end
      if (w_idx == acr_pkg::IDX_CFG2) begin
        cfg2_reg <= wbyte & acr_pkg::C2_WMASK;
      end
      if (w_idx == acr_pkg::IDX_CFG3) begin
        cfg3_reg <= wbyte & acr_pkg::C3_WMASK;
      end
    end
  end

  // every write to register 1 with byte lane 0 strobed starts a conversion
  assign start_pulse = do_write && w_strb_reg[0] && (w_idx == acr_pkg::IDX_CFG1);

  // reading the result word counts as reading conversion data
  assign result_read = do_read && (r_idx == acr_pkg::IDX_RESULT);
  assign clear_ready = result_read;

  // the result word is captured together with the flag
  // ready flag, set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
      result_reg <= 16'h0000;
    end else if (result_valid) begin
      ready_reg <= 1'b1;
      result_reg <= result_data;
    end else if (clear_ready) begin
      ready_reg <= 1'b0;
    end
  end

  // clearing while disabled keeps a stale count from coming back
  // counter advances per result when enabled
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 8'h00;
    end else if (!cfg2_reg[acr_pkg::C2_CNT_BIT]) begin
      count_reg <= 8'h00;
    end else if (result_valid) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // interrupt clear strobe from write-only register
  assign irq_clear = (do_write && w_strb_reg[0] && w_idx == acr_pkg::IDX_IRQ_CLEAR) ?
                     wbyte[acr_pkg::IRQ_W-1:0] : '0;

  // sticky status and enable, a new result beats a clear
  // enable is a plain read-write mask
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
    end else begin
      if (result_valid) begin
        irq_status_reg[acr_pkg::IRQ_READY_BIT] <= 1'b1;
      end else if (irq_clear[acr_pkg::IRQ_READY_BIT]) begin
        irq_status_reg[acr_pkg::IRQ_READY_BIT] <= 1'b0;
      end
      if (do_write && w_strb_reg[0] && w_idx == acr_pkg::IDX_IRQ_ENABLE) begin
        irq_enable_reg <= wbyte[acr_pkg::IRQ_W-1:0];
      end
    end
  end

  // level interrupt while any enabled status bit is set
  assign irq = |(irq_status_reg & irq_enable_reg);

  // read data mux
  // unmapped reads return zero with an error response
  always_comb begin
    rdata_next = 32'h0000_0000;
    rhit = acr_is_mapped(r_idx);
    unique case (r_idx)
      acr_pkg::IDX_CFG0: rdata_next[7:0] = cfg0_reg;
      acr_pkg::IDX_CFG1: rdata_next[7:0] = cfg1_reg;
      acr_pkg::IDX_CFG2: rdata_next[7:0] = {ready_reg, cfg2_reg[6:0]};
      acr_pkg::IDX_CFG3: rdata_next[7:0] = cfg3_reg;
      acr_pkg::IDX_IRQ_STATUS: rdata_next[acr_pkg::IRQ_W-1:0] = irq_status_reg;
      acr_pkg::IDX_IRQ_ENABLE: rdata_next[acr_pkg::IRQ_W-1:0] = irq_enable_reg;
      acr_pkg::IDX_IRQ_CLEAR: rdata_next = 32'h0000_0000;
      acr_pkg::IDX_RESULT: rdata_next[15:0] = result_reg;
      acr_pkg::IDX_COUNT: rdata_next[7:0] = count_reg;
      acr_pkg::IDX_RATE: rdata_next[11:0] = output_rate_sps;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read response registered
  // arready stays low while a response waits, so one read at a time
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= acr_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rhit ? acr_pkg::RESP_OKAY : acr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // the table is registered, so the rate trails the code by one cycle
  // rate code
  acr_rate_lut u_rate (
    .clock(clock),
    .rst_n(rst_n),
    .rate_code(cfg1_reg[acr_pkg::C1_RATE_LSB +: 3]),
    .turbo(cfg1_reg[acr_pkg::C1_TURBO_BIT]),
    .rate_sps(output_rate_sps)
  );

  // stored register 0 still reads back unchanged in temperature mode
  // temperature mode forces register 0 defaults
  assign input_mux_sel = temp_sensor_mode_en ? 4'h0 : cfg0_reg[acr_pkg::C0_MUX_LSB +: 4];
  assign gain_code = temp_sensor_mode_en ? 3'h0 : cfg0_reg[acr_pkg::C0_GAIN_LSB +: 3];
  assign amp_bypass = temp_sensor_mode_en ? 1'b0 : cfg0_reg[acr_pkg::C0_BYP_BIT];
  assign temp_sensor_mode_en = cfg1_reg[acr_pkg::C1_TEMP_BIT];
  assign output_rate_code = cfg1_reg[acr_pkg::C1_RATE_LSB +: 3];
  assign turbo_mode_sel = cfg1_reg[acr_pkg::C1_TURBO_BIT];
  assign conversion_mode_sel = cfg1_reg[acr_pkg::C1_CONT_BIT];

  always_comb begin
    if (temp_sensor_mode_en || cfg1_reg[acr_pkg::C1_REF_LSB +: 2] == 2'b00) begin
      reference_sel = acr_pkg::ACR_REF_INTERNAL;
    end else if (cfg1_reg[acr_pkg::C1_REF_LSB +: 2] == 2'b01) begin
      reference_sel = acr_pkg::ACR_REF_EXTERNAL;
    end else begin
      reference_sel = acr_pkg::ACR_REF_SUPPLY;
    end
  end

  // register 2 and 3 fields straight from storage
  // counter enable
  assign sample_counter_en = cfg2_reg[acr_pkg::C2_CNT_BIT];
  assign integrity_check_sel = cfg2_reg[acr_pkg::C2_CHK_LSB +: 2];
  assign burnout_source_en = cfg2_reg[acr_pkg::C2_BURN_BIT];
  assign excitation_current_level = cfg2_reg[acr_pkg::C2_LEVEL_LSB +: 3];
  assign exc_src1_route = cfg3_reg[acr_pkg::C3_SRC1_LSB +: 3];
  assign exc_src2_route = cfg3_reg[acr_pkg::C3_SRC2_LSB +: 3];
  assign auto_output_en = cfg3_reg[acr_pkg::C3_AUTO_BIT];
endmodule : acr_regs
`default_nettype wire

/* dv/acr_rate_ref.svh */
// expected output data rate for a rate code and modulator mode
function automatic logic [11:0] rate_ref(input logic [2:0] c, input logic t);
  logic [11:0] n [8];
  n = '{12'h014, 12'h02D, 12'h05A, 12'h0AF, 12'h14A, 12'h258, 12'h3E8, 12'h000};
  // turbo doubles every code, so 001 gives 90
  return (t && c == 3'h1) ? 12'h05A : (t ? n[c] << 1 : n[c]);
endfunction : rate_ref

/* dv/acr_regs_checker.sv */
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module acr_regs_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // controls
  input wire logic [2:0] output_rate_code,
  input wire logic turbo_mode_sel,
  input wire logic [1:0] reference_sel,
  input wire logic temp_sensor_mode_en,
  input wire logic [3:0] input_mux_sel,
  input wire logic [2:0] gain_code,
  input wire logic amp_bypass,
  input wire logic [11:0] output_rate_sps
);
  `include "acr_rate_ref.svh"
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [5:0] rd_idx_reg;
  // index of the read in flight
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rd_idx_reg <= 6'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_idx_reg <= s_axi_araddr[7:2];
  end
  property p_temp;
    temp_sensor_mode_en |-> reference_sel == 2'h0 && input_mux_sel == 4'h0 && gain_code == 3'h0 && !amp_bypass;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature mode left an override open");
  property p_rate;
    $changed(output_rate_code) || $changed(turbo_mode_sel)
      |=> output_rate_sps == rate_ref($past(output_rate_code), $past(turbo_mode_sel));
  endproperty
  a_rate: assert property (p_rate) else $error("rate does not follow code and mode");
  property p_ref;
    reference_sel != 2'h3;
  endproperty
  a_ref: assert property (p_ref) else $error("supply reference has two encodings");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_arready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_arready: assert property (p_arready) else $error("read address ready wrong");
  property p_rdlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rdlat: assert property (p_rdlat) else $error("read answer late");
  property p_rsvd;
    s_axi_rvalid && rd_idx_reg == 6'h03 |-> s_axi_rdata[1] == 1'b0 && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit of register 3 set");
  property p_rst;
    $rose(rst_n) |-> output_rate_sps == 12'h000 && output_rate_code == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("controls not cleared by reset");
  c_temp: cover property (temp_sensor_mode_en);
  c_turbo: cover property (turbo_mode_sel && output_rate_code == 3'h6);
  c_rd3: cover property (s_axi_rvalid && rd_idx_reg == 6'h03);
endmodule : acr_regs_checker
bind acr_regs acr_regs_checker acr_regs_checker_i (.clock, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .output_rate_code, .turbo_mode_sel,
  .reference_sel, .temp_sensor_mode_en, .input_mux_sel, .gain_code, .amp_bypass, .output_rate_sps);
`default_nettype wire

/* dv/acr_conv_model.sv */
// converter engine stand-in: answers each start with one result, then one every LAT cycles while continuous
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model #(
  parameter int LAT = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control from the register bank
  input wire logic start_pulse,
  input wire logic conversion_mode_sel,
  // result to the register bank
  output logic result_valid,
  output logic [15:0] result_data
);
  int cnt_reg;
  logic [7:0] seq_reg;
  // countdown to the next result, rearmed while continuous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 0;
      seq_reg <= 8'h00;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (start_pulse) cnt_reg <= LAT;
      else if (cnt_reg == 1) begin
        result_valid <= 1'b1;
        seq_reg <= seq_reg + 8'h01;
        cnt_reg <= conversion_mode_sel ? LAT : 0;
      end else if (cnt_reg > 1) cnt_reg <= cnt_reg - 1;
    end
  end
  // data means something only with the strobe, so it is scrambled otherwise
  assign result_data = result_valid ? {8'hC3, seq_reg} : {8'h3C, ~seq_reg};
endmodule : acr_conv_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  `include "acr_rate_ref.svh"
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, result_valid, start_pulse, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_sel, integrity_check_sel;
  logic [31:0] s_axi_rdata, v;
  logic [15:0] result_data;
  logic [3:0] input_mux_sel;
  logic [2:0] gain_code, output_rate_code, excitation_current_level, exc_src1_route, exc_src2_route;
  logic amp_bypass, turbo_mode_sel, conversion_mode_sel, temp_sensor_mode_en;
  logic sample_counter_en, burnout_source_en, auto_output_en;
  logic [11:0] output_rate_sps;
  int errors = 0, compares = 0, nres = 0;
  acr_regs acr_regs_i (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .result_valid, .result_data,
    .start_pulse, .input_mux_sel, .gain_code, .amp_bypass, .output_rate_code, .turbo_mode_sel,
    .conversion_mode_sel, .reference_sel, .temp_sensor_mode_en, .sample_counter_en, .integrity_check_sel,
    .burnout_source_en, .excitation_current_level, .exc_src1_route, .exc_src2_route, .auto_output_en,
    .output_rate_sps, .irq);
  acr_conv_model acr_conv_model_i (.clock, .rst_n, .start_pulse, .conversion_mode_sel, .result_valid, .result_data);
  always #5 clock = ~clock;
  // count results handed over, for the expected result word
  always @(posedge clock) if (result_valid) nres <= nres + 1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // fresh request per access
  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er = acr_pkg::RESP_OKAY);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask : wr
  // one read, data and response compared
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er = acr_pkg::RESP_OKAY);
    @(posedge clock);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", s_axi_rresp, er);
  endtask : rd
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 1; i < 4; i++) rd(i[7:0], 32'h0000_0000);
    wr(acr_pkg::IDX_CFG2, 32'h0000_00D6);
    wr(acr_pkg::IDX_CFG3, 32'h0000_00A7);
    rd(acr_pkg::IDX_CFG2, 32'h0000_0056);
    rd(acr_pkg::IDX_CFG3, 32'h0000_00A5);
    chk("reg2", {sample_counter_en, integrity_check_sel, burnout_source_en, excitation_current_level}, 32'h56);
    chk("reg3 fields", {exc_src1_route, exc_src2_route, auto_output_en}, 32'h0000_0053);
    wr(acr_pkg::IDX_CFG0, 32'h0000_00FF);
    wr(acr_pkg::IDX_CFG1, 32'h0000_0003);
    chk("temp override", {input_mux_sel, gain_code, amp_bypass, reference_sel}, 32'h0000_0000);
    wr(acr_pkg::IDX_CFG1, 32'h0000_0002);
    chk("reg0 fields", {input_mux_sel, gain_code, amp_bypass, reference_sel}, 32'h0000_03FD);
    // every rate code in both modes, with reference and conversion mode swept
    for (int i = 0; i < 16; i++) begin
      v = {24'h00_0000, i[2:0], i[3], i[0], i[1:0], 1'b0};
      wr(acr_pkg::IDX_CFG1, v);
      repeat (2) @(posedge clock);
      chk("rate", output_rate_sps, rate_ref(i[2:0], i[3]));
      chk("rate code", output_rate_code, i[2:0]);
      chk("mode bits", {turbo_mode_sel, conversion_mode_sel}, {i[3], i[0]});
      chk("reference", reference_sel, i[1:0] == 2'h3 ? 2'h2 : i[1:0]);
      rd(acr_pkg::IDX_CFG1, v);
      rd(acr_pkg::IDX_RATE, {20'h0_0000, rate_ref(i[2:0], i[3])});
    end
    wr(acr_pkg::IDX_CFG1, 32'h0000_0000);
    repeat (30) @(posedge clock);
    rd(acr_pkg::IDX_RESULT, {16'h0000, 8'hC3, nres[7:0]});
    wr(acr_pkg::IDX_IRQ_CLEAR, 32'h0000_0001);
    wr(acr_pkg::IDX_IRQ_ENABLE, 32'h0000_0001);
    chk("irq idle", irq, 32'h0000_0000);
    wr(acr_pkg::IDX_CFG1, 32'h0000_0000);
    for (int k = 0; k < 50 && !irq; k++) @(posedge clock);
    chk("irq raised", irq, 32'h0000_0001);
    rd(acr_pkg::IDX_CFG2, 32'h0000_00D6);
    rd(acr_pkg::IDX_RESULT, {16'h0000, 8'hC3, nres[7:0]});
    rd(acr_pkg::IDX_CFG2, 32'h0000_0056);
    wr(acr_pkg::IDX_IRQ_CLEAR, 32'h0000_0001);
    chk("irq cleared", irq, 32'h0000_0000);
    wr(acr_pkg::IDX_IRQ_ENABLE, 32'h0000_0000);
    wr(acr_pkg::IDX_CFG1, 32'h0000_0000);
    repeat (30) @(posedge clock);
    chk("irq masked", irq, 32'h0000_0000);
    rd(acr_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
    rd(acr_pkg::IDX_COUNT, {24'h00_0000, nres[7:0]});
    wr(acr_pkg::IDX_CFG2, 32'h0000_0016);
    rd(acr_pkg::IDX_COUNT, 32'h0000_0000);
    wr(8'h20, 32'h0000_00FF, acr_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, acr_pkg::RESP_SLVERR);
    summarize();
  end
  // cut a hang short, far beyond the expected run length
  initial begin
    #100_000;
    errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
